// ### inc/dma_master_consts.vh
`ifndef DMA_MASTER_CONSTS_VH
`define DMA_MASTER_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------
`define OFF_PCI_START 8'h40
`define OFF_RAM_START 8'h44
`define OFF_CONTROL 8'h48

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_DONE_BIT 1
`define CTL_DIR_BIT 3
`define CTL_START_BIT 4
`define CTL_IE_BIT 7
`define CTL_LEN_LSB 16
`define CTL_LEN_MSB 27
`define CTL_LEN_W 12
`define CNT_W 11
`define LEN_ZERO_WORDS 11'h400
`define CTL_RESET 32'h00000000

// ----------------------------------------------------------------
// Bus command codes and byte enables
// ----------------------------------------------------------------
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define BE_ALL_BYTES 4'h0
`define DW_STEP 32'h00000004
`define PIPE_DEPTH 3'h2

`endif

// ### src/dma_word_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "dma_master_consts.vh"

module dma_word_counter (
   input wire sys_clk,
   input wire rst,
   input wire load,
   input wire [`CNT_W-1:0] load_val,
   input wire dec,
   output wire [`CNT_W-1:0] count,
   output wire last,
   output wire empty
);

   reg [`CNT_W-1:0] count_q;

   // ----------------------------------------------------------------
   // Down counter of double words still to go
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst) begin
         count_q <= {`CNT_W{1'b0}};
      end else if (load) begin
         count_q <= load_val;
      end else if (dec && count_q != {`CNT_W{1'b0}}) begin
         count_q <= count_q - {{(`CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Flags for the final word and exhaustion
   assign count = count_q;
   assign last = (count_q == {{(`CNT_W-1){1'b0}}, 1'b1});
   assign empty = (count_q == {`CNT_W{1'b0}});

endmodule

`default_nettype wire

// ### src/pci_dma_master.v
// How it works
// R01 - Win bus by request and grant first
// R02 - Address phase: frame, address, command 0110
// R03 - Read: bus words stored into back-end memory
// R04 - Assert initiator ready, take word on target ready
// R05 - Read burst runs until length moved
// R06 - Zero-wait and paced bursts both work
// R07 - Write: no frame before grant seen
// R08 - Write: back-end words driven onto bus
// R09 - Write: initiator ready only when data held
// R10 - Write burst ends when length moved
// R11 - Software loads both start addresses first
// R12 - Length field 27:16, zero means 1024
// R13 - Control bit 4 starts, bit 3 direction
// R14 - Completion sets bit 1, interrupt if enabled
// R15 - Frame drops on last phase, then release
// R16 - Both addresses advance one dword per phase
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dma_master_consts.vh"

module pci_dma_master (
   input wire sys_clk,
   input wire rst,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   output wire dma_irq,
   output wire req_n,
   input wire gnt_n,
   input wire frame_n_i,
   output wire frame_n_o,
   output wire frame_n_oe,
   input wire irdy_n_i,
   output wire irdy_n_o,
   output wire irdy_n_oe,
   input wire trdy_n_i,
   input wire [31:0] ad_i,
   output wire [31:0] ad_o,
   output wire ad_oe,
   output wire [3:0] cbe_o,
   output wire cbe_oe,
   output wire [31:0] be_addr,
   output wire [31:0] be_wdata,
   output wire be_we,
   output wire be_rd,
   input wire [31:0] be_rdata,
   input wire be_rvalid
);

   // ----------------------------------------------------------------
   // States and helpers
   // ----------------------------------------------------------------
   localparam ST_IDLE = 3'd0;
   localparam ST_REQ = 3'd1;
   localparam ST_ADDR = 3'd2;
   localparam ST_DATA = 3'd3;
   localparam ST_END = 3'd4;

   // Length field to word count; an all-zero field gives 1024 words, any other its low 11 bits
   function [`CNT_W-1:0] decode_len;
      input [`CTL_LEN_W-1:0] field;
      begin
         if (field == {`CTL_LEN_W{1'b0}}) begin
            decode_len = `LEN_ZERO_WORDS;
         end else begin
            decode_len = field[`CNT_W-1:0];
         end
      end
   endfunction

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [31:0] pci_start_q;
   reg [31:0] ram_start_q;
   reg [`CTL_LEN_W-1:0] len_q;
   reg ie_q;
   reg dir_q;
   reg done_q;
   reg req_n_q;
   reg [31:0] pci_addr_q;
   reg [31:0] be_addr_q;
   reg [31:0] be_wdata_q;
   reg be_we_q;
   reg [31:0] pipe_q [0:1];
   reg wp_q;
   reg rp_q;
   reg [1:0] occ_q;
   reg [1:0] pend_q;

   wire ctl_wr;
   wire start;
   wire irdy_on;
   wire xfer;
   wire last;
   wire fetch_left_empty;
   wire [2:0] in_flight;
   wire fill_phase;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   assign ctl_wr = reg_wr && (reg_addr == `OFF_CONTROL);
   // A start while a burst runs is dropped: counters must not reload mid-burst
   assign start = ctl_wr && reg_wdata[`CTL_START_BIT] && (state_q == ST_IDLE); // R13

   // Stored configuration
   always @(posedge sys_clk) begin
      if (rst) begin
         pci_start_q <= 32'h00000000;
         ram_start_q <= 32'h00000000;
         len_q <= {`CTL_LEN_W{1'b0}};
         ie_q <= 1'b0;
         dir_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `OFF_PCI_START) begin
            pci_start_q <= reg_wdata; // R11
         end
         if (reg_wr && reg_addr == `OFF_RAM_START) begin
            ram_start_q <= reg_wdata; // R11
         end
         if (ctl_wr && state_q == ST_IDLE) begin
            len_q <= reg_wdata[`CTL_LEN_MSB:`CTL_LEN_LSB]; // R12
            ie_q <= reg_wdata[`CTL_IE_BIT];
            dir_q <= reg_wdata[`CTL_DIR_BIT]; // R13
         end else if (ctl_wr) begin
            ie_q <= reg_wdata[`CTL_IE_BIT];
         end
      end
   end

   // Completion flag; a new completion beats a clearing write
   always @(posedge sys_clk) begin
      if (rst) begin
         done_q <= 1'b0;
      end else if (state_q == ST_END) begin
         done_q <= 1'b1; // R14
      end else if (start || (ctl_wr && reg_wdata[`CTL_DONE_BIT])) begin
         done_q <= 1'b0;
      end
   end

   assign dma_irq = done_q && ie_q; // R14

   // Read data one cycle after the strobe, zero elsewhere
   always @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFF_PCI_START: reg_rdata <= pci_start_q;
            `OFF_RAM_START: reg_rdata <= ram_start_q;
            `OFF_CONTROL: begin
               reg_rdata <= `CTL_RESET;
               reg_rdata[`CTL_LEN_MSB:`CTL_LEN_LSB] <= len_q;
               reg_rdata[`CTL_IE_BIT] <= ie_q;
               reg_rdata[`CTL_START_BIT] <= (state_q != ST_IDLE);
               reg_rdata[`CTL_DIR_BIT] <= dir_q;
               reg_rdata[`CTL_DONE_BIT] <= done_q;
            end
            default: reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // Word counters: bus phases left, back-end fetches left
   // ----------------------------------------------------------------
   dma_word_counter u_phase_cnt (
      .sys_clk(sys_clk),
      .rst(rst),
      .load(start),
      .load_val(decode_len(reg_wdata[`CTL_LEN_MSB:`CTL_LEN_LSB])),
      .dec(xfer),
      .count(),
      .last(last),
      .empty()
   );

   dma_word_counter u_fetch_cnt (
      .sys_clk(sys_clk),
      .rst(rst),
      .load(start),
      .load_val(decode_len(reg_wdata[`CTL_LEN_MSB:`CTL_LEN_LSB])),
      .dec(be_rd),
      .count(),
      .last(),
      .empty(fetch_left_empty)
   );

   // ----------------------------------------------------------------
   // Bus sequencer
   // ----------------------------------------------------------------
   // Read: ready every data cycle; write: only while a word is held
   assign irdy_on = (state_q == ST_DATA) && (dir_q ? (occ_q != 2'd0) : 1'b1); // R04 R09
   assign xfer = irdy_on && !trdy_n_i; // R04 R06

   // Next-state selection
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               state_d = ST_REQ;
            end
         end
         ST_REQ: begin
            // Grant and an idle bus before any drive
            if (!gnt_n && frame_n_i && irdy_n_i) begin
               state_d = ST_ADDR; // R01 R07
            end
         end
         ST_ADDR: state_d = ST_DATA; // R02
         ST_DATA: begin
            if (xfer && last) begin
               state_d = ST_END; // R05 R10
            end
         end
         ST_END: state_d = ST_IDLE; // R15
         default: state_d = ST_IDLE;
      endcase
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Request held from start until the address phase begins
   always @(posedge sys_clk) begin
      if (rst) begin
         req_n_q <= 1'b1;
      end else if (start) begin
         req_n_q <= 1'b0; // R01
      end else if (state_d == ST_ADDR || state_q == ST_IDLE) begin
         req_n_q <= 1'b1;
      end
   end

   assign req_n = req_n_q;

   // Frame drops with ready on the final phase; END drives both high once
   assign frame_n_o = (state_q == ST_DATA) ? (last && irdy_on) : (state_q != ST_ADDR); // R15
   assign irdy_n_o = !irdy_on; // R04 R15
   assign frame_n_oe = (state_q == ST_ADDR) || (state_q == ST_DATA) || (state_q == ST_END);
   assign irdy_n_oe = frame_n_oe;

   // Address, command and write data
   assign ad_o = (state_q == ST_ADDR) ? pci_addr_q : pipe_q[rp_q]; // R02 R08
   assign ad_oe = (state_q == ST_ADDR) || ((state_q == ST_DATA) && dir_q);
   assign cbe_o = (state_q == ST_ADDR) ?
                  (dir_q ? `CMD_MEM_WRITE : `CMD_MEM_READ) : `BE_ALL_BYTES; // R02
   assign cbe_oe = (state_q == ST_ADDR) || (state_q == ST_DATA);

   // PCI address advances per completed phase
   always @(posedge sys_clk) begin
      if (rst) begin
         pci_addr_q <= 32'h00000000;
      end else if (start) begin
         pci_addr_q <= pci_start_q;
      end else if (xfer && state_q == ST_DATA) begin
         pci_addr_q <= pci_addr_q + `DW_STEP; // R16
      end
   end

   // ----------------------------------------------------------------
   // Back-end side
   // ----------------------------------------------------------------
   // Read direction: each accepted bus word is stored one cycle later
   always @(posedge sys_clk) begin
      if (rst) begin
         be_we_q <= 1'b0;
         be_wdata_q <= 32'h00000000;
      end else begin
         be_we_q <= xfer && !dir_q; // R03
         if (xfer && !dir_q) begin
            be_wdata_q <= ad_i; // R03
         end
      end
   end

   assign be_we = be_we_q;
   assign be_wdata = be_wdata_q;

   // Back-end address: bumps after each store or each fetch issue
   always @(posedge sys_clk) begin
      if (rst) begin
         be_addr_q <= 32'h00000000;
      end else if (start) begin
         be_addr_q <= ram_start_q;
      end else if (be_we_q || be_rd) begin
         be_addr_q <= be_addr_q + `DW_STEP; // R16
      end
   end

   assign be_addr = be_addr_q;

   // Write direction prefetch: fill during arbitration so the burst can stream
   assign fill_phase = (state_q == ST_REQ) || (state_q == ST_ADDR) || (state_q == ST_DATA);
   assign in_flight = {1'b0, occ_q} + {1'b0, pend_q};
   assign be_rd = dir_q && fill_phase && !fetch_left_empty && (in_flight < `PIPE_DEPTH); // R08 R09

   // Two-word pipe; outstanding fetches always have a free slot
   always @(posedge sys_clk) begin
      if (rst || start) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         occ_q <= 2'd0;
         pend_q <= 2'd0;
      end else begin
         if (be_rvalid && pend_q != 2'd0) begin
            wp_q <= ~wp_q;
         end
         if (xfer && dir_q) begin
            rp_q <= ~rp_q; // R08
         end
         occ_q <= occ_q + {1'b0, be_rvalid && pend_q != 2'd0} - {1'b0, xfer && dir_q};
         pend_q <= pend_q + {1'b0, be_rd} - {1'b0, be_rvalid && pend_q != 2'd0};
      end
   end

   // Pipe storage
   always @(posedge sys_clk) begin
      if (be_rvalid && pend_q != 2'd0) begin
         pipe_q[wp_q] <= be_rdata;
      end
   end

endmodule

`default_nettype wire

// ### tb/pci_dma_master_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pci_dma_master_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic req_n,
   input wire logic gnt_n,
   input wire logic frame_n_o,
   input wire logic frame_n_oe,
   input wire logic irdy_n_o,
   input wire logic irdy_n_oe,
   input wire logic trdy_n_i,
   input wire logic [31:0] ad_i,
   input wire logic ad_oe,
   input wire logic [3:0] cbe_o,
   input wire logic cbe_oe,
   input wire logic [31:0] be_addr,
   input wire logic [31:0] be_wdata,
   input wire logic be_we
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Completed data phase, and one of a read burst
   wire go = irdy_n_oe && !irdy_n_o && !trdy_n_i;
   wire rd_go = go && !ad_oe;
   // ----------------
   // Bus phases
   // ----------------
   chk_frame_after_gnt: assert property ($rose(frame_n_oe) |-> !$past(gnt_n))
      else $error("frame driven without grant");
   chk_req_release: assert property ($rose(frame_n_oe) |-> req_n)
      else $error("request kept in address phase");
   chk_addr_phase: assert property ($rose(frame_n_oe) |-> !frame_n_o && cbe_oe
      && cbe_o[3:1] == 3'h3)
      else $error("bad address phase");
   chk_cmd_dir: assert property ($rose(frame_n_oe) |=> ad_oe == $past(cbe_o[0]))
      else $error("command and data direction differ");
   chk_data_enables: assert property (irdy_n_oe && !irdy_n_o |-> cbe_o == 4'h0)
      else $error("byte enables wrong in data phase");
   chk_store_on_trdy: assert property (be_we |-> $past(rd_go))
      else $error("store without completed phase");
   chk_read_store: assert property (rd_go |=> be_we && be_wdata == $past(ad_i))
      else $error("bus word not stored");
   chk_be_step: assert property (be_we && $past(be_we) |-> be_addr == $past(be_addr) + 32'h4)
      else $error("back-end address step wrong");
   chk_frame_release: assert property (frame_n_oe && frame_n_o && go |=> irdy_n_o || !irdy_n_oe)
      else $error("initiator ready kept after last phase");
   cover property ($rose(frame_n_oe) && cbe_o == 4'h6);
   cover property ($rose(frame_n_oe) && cbe_o == 4'h7);
   cover property (go ##1 !go ##1 go);
endmodule
bind pci_dma_master pci_dma_master_checker u_chk (.sys_clk, .rst, .req_n, .gnt_n, .frame_n_o,
   .frame_n_oe, .irdy_n_o, .irdy_n_oe, .trdy_n_i, .ad_i, .ad_oe, .cbe_o, .cbe_oe, .be_addr,
   .be_wdata, .be_we);
`default_nettype wire

// ### tb/pci_dma_master_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_master_consts.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module pci_dma_master_tb;
   logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, paced = 1'b0, rd_seen_q = 1'b0;
   logic [7:0] reg_addr = 8'h00, lfsr_q = 8'h5C;
   logic [31:0] reg_wdata = 32'h0, pci_a, ram_a;
   wire logic dma_irq, req_n, gnt_n, frame_n_i, frame_n_o, frame_n_oe, irdy_n_i, irdy_n_o;
   wire logic irdy_n_oe, trdy_n_i, ad_oe, cbe_oe, be_we, be_rd, be_rvalid;
   wire logic [31:0] reg_rdata, ad_i, ad_o, be_addr, be_wdata, be_rdata;
   wire logic [3:0] cbe_o;
   int bad_count = 0, num_checks = 0;
   logic [31:0] exp_q[$];
   logic [31:0] bea_q[$];
   logic [31:0] exp_v, bea_v;
   pci_dma_master DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .dma_irq, .req_n, .gnt_n, .frame_n_i, .frame_n_o, .frame_n_oe, .irdy_n_i, .irdy_n_o,
      .irdy_n_oe, .trdy_n_i, .ad_i, .ad_o, .ad_oe, .cbe_o, .cbe_oe, .be_addr, .be_wdata,
      .be_we, .be_rd, .be_rdata, .be_rvalid);
   pci_far_side FAR (.sys_clk, .rst, .paced, .req_n, .gnt_n, .frame_n_o, .frame_n_oe,
      .frame_n_i, .irdy_n_o, .irdy_n_oe, .irdy_n_i, .trdy_n_i, .ad_o, .ad_oe, .ad_i, .be_addr,
      .be_rd, .be_rdata, .be_rvalid);
   always #4 sys_clk = ~sys_clk;
   function automatic logic [7:0] lfsr(input logic [7:0] q);
      return {q[6:0], q[7] ^ q[5] ^ q[4] ^ q[3]};
   endfunction
   // Expected word per address; s picks bus side or back-end side
   function automatic logic [31:0] word_pat(input logic [31:0] a, input logic s);
      return {a[15:0] ^ {s, 15'h2A5C}, ~a[31:16]};
   endfunction
   // ----------------
   // Register port; each task raises one strobe and drops the other, idle drops both
   // ----------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; reg_rd <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      reg_addr <= a; reg_rd <= 1'b1; reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic idle;
      reg_wr <= 1'b0; reg_rd <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Watcher: every stored word, driven bus word and read answer
   always @(posedge sys_clk) if (!rst) begin
      rd_seen_q <= reg_rd;
      if (rd_seen_q || be_we || (ad_oe && irdy_n_oe && !irdy_n_o && !trdy_n_i)) begin
         if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
         else begin
            // Popped once here: the compare macro reads its arguments twice
            exp_v = exp_q.pop_front();
            `CHK(rd_seen_q ? reg_rdata : be_we ? be_wdata : ad_o, exp_v)
         end
      end
      // Each store lands at the next back-end address
      if (be_we) begin
         if (bea_q.size() == 0) `CHK(1'b1, 1'b0)
         else begin
            bea_v = bea_q.pop_front();
            `CHK(be_addr, bea_v)
         end
      end
   end
   // One burst; a busy rewrite of control must not change it
   task automatic run(input logic dir, input logic [11:0] len, input logic pc);
      int n;
      int i;
      n = (len == 12'h000) ? 1024 : int'(len);
      lfsr_q = lfsr(lfsr_q);
      pci_a = {16'h8000, lfsr_q, 8'h00};
      ram_a = {16'h0010, ~lfsr_q, 8'h00};
      paced <= pc;
      for (i = 0; i < n; i++) begin
         exp_q.push_back(word_pat((dir ? ram_a : pci_a) + (32'(i) << 2), dir));
         if (!dir) bea_q.push_back(ram_a + (32'(i) << 2));
      end
      wr(`OFF_PCI_START, pci_a);
      wr(`OFF_RAM_START, ram_a);
      wr(`OFF_CONTROL, {4'h0, len, 8'h00, 4'h9, dir, 3'h0});
      wr(`OFF_CONTROL, {4'h0, 12'h002, 8'h00, 8'h98});
      idle;
      for (i = 0; i < 5000 && dma_irq !== 1'b1; i++) @(posedge sys_clk);
      if (dma_irq !== 1'b1) begin
         bad_count++;
         summarize;
      end
      `CHK(exp_q.size(), 0)
      `CHK(bea_q.size(), 0)
      rd(`OFF_CONTROL, {4'h0, len, 8'h00, 4'h8, dir, 3'h2});
      wr(`OFF_CONTROL, {4'h0, len, 16'h0000});
      rd(`OFF_CONTROL, {4'h0, len, 16'h0002});
      idle;
      `CHK(dma_irq, 1'b0)
      wr(`OFF_CONTROL, 32'h00000082);
      rd(`OFF_CONTROL, 32'h00000080);
      idle;
      `CHK(dma_irq, 1'b0)
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd(8'h4C, 32'h00000000);
      run(1'b0, 12'h004, 1'b0);
      run(1'b0, 12'h005, 1'b1);
      run(1'b1, 12'h004, 1'b0);
      run(1'b1, 12'h007, 1'b1);
      run(1'b0, 12'h000, 1'b0);
      repeat (4) @(posedge sys_clk);
      summarize;
   end
endmodule
`default_nettype wire

// ### tb/pci_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module pci_far_side (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic paced,
   input wire logic req_n,
   output logic gnt_n,
   input wire logic frame_n_o,
   input wire logic frame_n_oe,
   output logic frame_n_i,
   input wire logic irdy_n_o,
   input wire logic irdy_n_oe,
   output logic irdy_n_i,
   output logic trdy_n_i,
   input wire logic [31:0] ad_o,
   input wire logic ad_oe,
   output logic [31:0] ad_i,
   input wire logic [31:0] be_addr,
   input wire logic be_rd,
   output logic [31:0] be_rdata,
   output logic be_rvalid
);
   logic in_tx_q, ph_q;
   logic [2:0] v_q;
   logic [31:0] addr_q, junk_q, d0_q, d1_q, d2_q;
   // Word pattern per address; s picks bus side or back-end side
   function automatic logic [31:0] pat(input logic [31:0] a, input logic s);
      return {a[15:0] ^ {s, 15'h2A5C}, ~a[31:16]};
   endfunction
   // ----------------
   // Wires: pulled up when released, junk on a floating AD
   // ----------------
   assign frame_n_i = frame_n_oe ? frame_n_o : 1'b1;
   assign irdy_n_i = irdy_n_oe ? irdy_n_o : 1'b1;
   assign trdy_n_i = !(in_tx_q && (!paced || ph_q));
   assign ad_i = ad_oe ? ad_o : (!trdy_n_i ? pat(addr_q, 1'b0) : junk_q);
   assign be_rvalid = paced ? v_q[2] : v_q[0];
   assign be_rdata = be_rvalid ? (paced ? d2_q : d0_q) : junk_q;
   // Arbiter, target and back-end memory; slow mode paces target and memory, not the arbiter
   always @(posedge sys_clk) begin
      gnt_n <= req_n;
      junk_q <= ~junk_q;
      v_q <= {v_q[1:0], be_rd};
      d0_q <= pat(be_addr, 1'b1);
      d1_q <= d0_q;
      d2_q <= d1_q;
      ph_q <= in_tx_q & ~ph_q;
      if (frame_n_oe && !frame_n_o && !in_tx_q) begin
         in_tx_q <= 1'b1;
         addr_q <= ad_o;
      end else if (!irdy_n_i && !trdy_n_i) begin
         addr_q <= addr_q + 32'h00000004;
         if (frame_n_i) in_tx_q <= 1'b0;
      end
      if (rst) begin
         gnt_n <= 1'b1;
         in_tx_q <= 1'b0;
         v_q <= 3'h0;
         junk_q <= 32'h0F0F0F0F;
      end
   end
endmodule
`default_nettype wire
